// [verilog/plc_panel_local.sv]
`timescale 1ns/10ps
// Purpose: operator keypad gating, local/remote handover, mains_on_behaviour_sel
// Assumes: keys and digital inputs are asynchronous pins; settings
//   arrive as one-cycle writes from keypad editor or serial port
// Notes: keys other than jog are acted on at their rising edge after synchronising; jog acts while held
module plc_panel_local
	import plc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// keypad and external pins (asynchronous)
	input wire logic keyStop,
	input wire logic keyStart,
	input wire logic keyJog,
	input wire logic keyDir,
	input wire logic keyReset,
	input wire logic keyStatus,
	input wire logic dinRun,
	// operating context (same clock)
	input wire logic localSel,
	input wire logic [plc_pkg::REF_W-1:0] remoteRef,
	input wire logic [plc_pkg::REF_W-1:0] presentRef,
	input wire logic dirReversible,
	input wire logic [1:0] storedConfig,
	input wire logic [3:0] dinFunction,
	input wire logic savedRunState,
	// parameter writes, one-cycle strobe
	input wire logic parWrite,
	input wire logic parFromSerial,
	input wire logic [3:0] parId,
	input wire logic [plc_pkg::REF_W-1:0] parData,
	// settings readback
	output logic [plc_pkg::DISP_W-1:0] disp1,
	output logic [plc_pkg::DISP_W-1:0] disp2,
	output logic [plc_pkg::DISP_W-1:0] disp3,
	output logic [2:0] panel_control_mode_sel,
	output logic stopEnable,
	output logic panel_inch_key_enable,
	output logic revEnable,
	output logic resetEnable,
	output logic dataLock,
	output logic [1:0] mains_on_behaviour_sel,
	// to motor control
	output logic showLine1,
	output logic [plc_pkg::REF_W-1:0] speedRef,
	output logic [1:0] configOut,
	output logic forceOpen,
	output logic inputsAccepted,
	output logic runCmd,
	output logic jogCmd,
	output logic dirReverse,
	output logic tripReset,
	output logic parRejected
);
	import plc_pkg::*;

	localparam int NPIN = 7;

	// ----------------------------------------------------------------
	// pin synchronisation and edge detection
	// ----------------------------------------------------------------
	plc_sync_if #(.W(NPIN)) pins ();
	assign pins.raw = {dinRun, keyStatus, keyReset, keyDir, keyJog,
		keyStart, keyStop};

	plc_pin_sync #(.W(NPIN)) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.port(pins)
	);

	logic [NPIN-1:0] pinPrev;
	logic [NPIN-1:0] rise;
	assign rise = pins.clean & ~pinPrev;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// open-loop family: codes 1 and 2
	function automatic logic isOpenMode(input logic [2:0] m);
		return (m == MODE_FORCED_OPEN) || (m == MODE_INPUTS_OPEN);
	endfunction : isOpenMode

	// modes that take speed from the local reference
	function automatic logic isLocalSpeed(input logic [2:0] m);
		return (m != MODE_OFF);
	endfunction : isLocalSpeed

	// reference sign lives in the top bit (two's complement)
	function automatic logic isNeg(input logic [REF_W-1:0] r);
		return r[REF_W-1];
	endfunction : isNeg

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [DISP_W-1:0] next_disp1, next_disp2, next_disp3;
	logic [2:0] next_mode;
	logic next_stopEn, next_jogEn, next_revEn, next_rstEn, next_lock;
	logic [1:0] next_pwr;
	logic [REF_W-1:0] localRef, next_localRef;
	logic next_run, next_jog, next_dir, next_trip, next_rej, next_show;
	logic localPrev, next_localPrev;
	logic pwrDone, next_pwrDone;
	logic [REF_W-1:0] next_speedRef;
	logic [1:0] next_configOut;
	logic editOk, keyEdit, localNow, toLocal, toRemote;

	assign keyEdit = parWrite && !parFromSerial;
	assign localNow = localSel;
	assign toLocal = pwrDone && localSel && !localPrev; // no edge at mains-on
	assign toRemote = pwrDone && !localSel && localPrev;

	// settings and reference next-state
	always_comb begin
		next_disp1 = disp1;
		next_disp2 = disp2;
		next_disp3 = disp3;
		next_mode = panel_control_mode_sel;
		next_stopEn = stopEnable;
		next_jogEn = panel_inch_key_enable;
		next_revEn = revEnable;
		next_rstEn = resetEnable;
		next_lock = dataLock;
		next_pwr = mains_on_behaviour_sel;
		next_localRef = localRef;
		next_rej = 1'b0;
		// display selectors stay editable under lock
		editOk = parFromSerial || !dataLock || (parId <= PAR_DISP3);
		if (parWrite && !editOk) begin
			next_rej = 1'b1;
		end else if (parWrite) begin
			case (parId)
				PAR_DISP1: next_disp1 = parData[DISP_W-1:0];
				PAR_DISP2: next_disp2 = parData[DISP_W-1:0];
				PAR_DISP3: next_disp3 = parData[DISP_W-1:0];
				PAR_MODE: begin
					// mode 0 may only be chosen while remote
					if (parData[2:0] == MODE_OFF && localSel)
						next_rej = 1'b1;
					else if (parData[2:0] > MODE_INPUTS_KEEP)
						next_rej = 1'b1;
					else
						next_mode = parData[2:0];
				end
				PAR_STOP: next_stopEn = parData[0];
				PAR_JOG: next_jogEn = parData[0];
				PAR_REV: next_revEn = parData[0];
				PAR_RST: next_rstEn = parData[0];
				PAR_LOCK: next_lock = parData[0];
				PAR_PWR: next_pwr = parData[1:0];
				PAR_LREF: begin
					if (panel_control_mode_sel == MODE_OFF)
						next_rej = 1'b1;
					else
						next_localRef = parData;
				end
				default: next_rej = 1'b1;
			endcase
		end
		// handover overrides a local reference edit in the same cycle
		if (toLocal && isOpenMode(panel_control_mode_sel)) begin
			// hold present frequency; zero if direction cannot reverse
			next_localRef = dirReversible ? presentRef : REF_ZERO;
		end else if (toLocal &&
				panel_control_mode_sel == MODE_INPUTS_KEEP) begin
			next_localRef = isNeg(presentRef) ? REF_ZERO : presentRef;
		end else if (toRemote) begin
			next_localRef = remoteRef;
		end
		// mains-on clear happens once, only in local
		if (!pwrDone && localNow && mains_on_behaviour_sel == PWR_STOP_ZERO)
			next_localRef = REF_ZERO;
	end

	// key actions and run state next-state
	always_comb begin
		next_run = runCmd;
		next_jog = 1'b0;
		next_dir = dirReverse;
		next_trip = 1'b0;
		next_show = rise[5];
		next_localPrev = localSel;
		next_pwrDone = 1'b1;
		if (!pwrDone) begin
			if (!localNow) begin
				// pulse start reads run off at mains on; remote run then follows the dinRun level
				next_run = (dinFunction == DIN_PULSE_START) ?
					1'b0 : pins.clean[6];
			end else if (mains_on_behaviour_sel == PWR_AUTO) begin
				next_run = savedRunState;
			end else begin
				next_run = 1'b0;
			end
		end else if (localNow) begin
			if (rise[1])
				next_run = 1'b1;
			if (rise[0] && stopEnable)
				next_run = 1'b0;
			if (panel_control_mode_sel == MODE_INPUTS_OPEN ||
					panel_control_mode_sel == MODE_INPUTS_KEEP)
				next_run = next_run | (rise[6]);
			if (rise[3] && revEnable &&
					(panel_control_mode_sel == MODE_FORCED_OPEN ||
					panel_control_mode_sel == MODE_KEEP_CONFIG))
				next_dir = !dirReverse;
		end else begin
			next_run = pins.clean[6];
			if (rise[0] && stopEnable)
				next_run = 1'b0;
		end
		if (panel_inch_key_enable && pins.clean[2])
			next_jog = 1'b1;
		if (resetEnable && rise[4])
			next_trip = 1'b1;
	end

	// speed and configuration paths
	always_comb begin
		next_speedRef = remoteRef;
		next_configOut = storedConfig;
		if (localNow && isLocalSpeed(panel_control_mode_sel)) begin
			next_speedRef = localRef;
			if (isOpenMode(panel_control_mode_sel))
				next_configOut = CFG_OPEN;
		end
		// leaving local in an open-loop mode: take the present output so there is no step
		if (toRemote && isOpenMode(panel_control_mode_sel))
			next_speedRef = presentRef;
	end

	assign forceOpen = localNow && isOpenMode(panel_control_mode_sel);
	assign inputsAccepted = !localNow ||
		panel_control_mode_sel == MODE_INPUTS_OPEN ||
		panel_control_mode_sel == MODE_INPUTS_KEEP;

	// registers; all settings take their defaults on reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			disp1 <= DISP1_DEF;
			disp2 <= DISP2_DEF;
			disp3 <= DISP3_DEF;
			panel_control_mode_sel <= MODE_DEF;
			stopEnable <= STOP_EN_DEF;
			panel_inch_key_enable <= JOG_EN_DEF;
			revEnable <= REV_EN_DEF;
			resetEnable <= RST_EN_DEF;
			dataLock <= LOCK_DEF;
			mains_on_behaviour_sel <= PWR_STOP_KEEP;
			localRef <= REF_ZERO;
			runCmd <= 1'b0;
			jogCmd <= 1'b0;
			dirReverse <= 1'b0;
			tripReset <= 1'b0;
			parRejected <= 1'b0;
			showLine1 <= 1'b0;
			localPrev <= 1'b0;
			pwrDone <= 1'b0;
			speedRef <= REF_ZERO;
			configOut <= CFG_OPEN;
			pinPrev <= '0;
		end else begin
			disp1 <= next_disp1;
			disp2 <= next_disp2;
			disp3 <= next_disp3;
			panel_control_mode_sel <= next_mode;
			stopEnable <= next_stopEn;
			panel_inch_key_enable <= next_jogEn;
			revEnable <= next_revEn;
			resetEnable <= next_rstEn;
			dataLock <= next_lock;
			mains_on_behaviour_sel <= next_pwr;
			localRef <= next_localRef;
			runCmd <= next_run;
			jogCmd <= next_jog;
			dirReverse <= next_dir;
			tripReset <= next_trip;
			parRejected <= next_rej;
			showLine1 <= next_show;
			localPrev <= next_localPrev;
			pwrDone <= next_pwrDone;
			speedRef <= next_speedRef;
			configOut <= next_configOut;
			pinPrev <= pins.clean;
		end
	end
endmodule : plc_panel_local

// [verilog/plc_pkg.sv]
// Purpose: shared constants and types for the panel local control block
// Assumes: one 10 MHz clock, asynchronous active-low reset
// Notes: selector codes follow the documented encodings
package plc_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DISP_W = 6;
	localparam int REF_W = 16;
	localparam int PAR_W = 8;
	// ----------------------------------------------------------------
	// display selector defaults
	// ----------------------------------------------------------------
	localparam logic [DISP_W-1:0] DISP1_DEF = 6'h01;
	localparam logic [DISP_W-1:0] DISP2_DEF = 6'h06;
	localparam logic [DISP_W-1:0] DISP3_DEF = 6'h08;
	localparam logic [1:0] IDX_D1 = 2'h0;
	localparam logic [1:0] IDX_D2 = 2'h1;
	localparam logic [1:0] IDX_D3 = 2'h2;
	// ----------------------------------------------------------------
	// local control mode codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_FORCED_OPEN = 3'h1,
		MODE_INPUTS_OPEN = 3'h2,
		MODE_KEEP_CONFIG = 3'h3,
		MODE_INPUTS_KEEP = 3'h4
	} plc_mode_t;
	localparam logic [2:0] MODE_DEF = 3'h4;
	// ----------------------------------------------------------------
	// mains_on_behaviour_sel codes
	// ----------------------------------------------------------------
	localparam logic [1:0] PWR_AUTO = 2'h0;
	localparam logic [1:0] PWR_STOP_KEEP = 2'h1;
	localparam logic [1:0] PWR_STOP_ZERO = 2'h2;
	// ----------------------------------------------------------------
	// other codes and defaults
	// ----------------------------------------------------------------
	localparam logic [1:0] CFG_OPEN = 2'h0;
	localparam logic [3:0] DIN_PULSE_START = 4'h8;
	localparam logic STOP_EN_DEF = 1'b1;
	localparam logic JOG_EN_DEF = 1'b0;
	localparam logic REV_EN_DEF = 1'b0;
	localparam logic RST_EN_DEF = 1'b1;
	localparam logic LOCK_DEF = 1'b0;
	localparam logic [REF_W-1:0] REF_ZERO = 16'h0000;
	// ----------------------------------------------------------------
	// parameter write target ids
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PAR_DISP1 = 4'h0,
		PAR_DISP2 = 4'h1,
		PAR_DISP3 = 4'h2,
		PAR_MODE = 4'h3,
		PAR_STOP = 4'h4,
		PAR_JOG = 4'h5,
		PAR_REV = 4'h6,
		PAR_RST = 4'h7,
		PAR_LOCK = 4'h8,
		PAR_PWR = 4'h9,
		PAR_LREF = 4'hA
	} plc_par_t;
endpackage : plc_pkg

// [verilog/plc_sync_if.sv]
`timescale 1ns/10ps
// Purpose: carrier between the top and its pin synchroniser
// Assumes: one clock domain on the synchronised side
// Notes: raw pins in, filtered levels out
interface plc_sync_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface : plc_sync_if

// [verilog/plc_pin_sync.sv]
`timescale 1ns/10ps
// Purpose: three-stage synchroniser for asynchronous panel pins
// Assumes: pins may change at any time
// Notes: a change counts once stages two and three agree
module plc_pin_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// pins
	plc_sync_if.sync port
);
	logic [W-1:0] s1, s2, s3, held;
	logic [W-1:0] next_held;

	// ----------------------------------------------------------------
	// filter
	// ----------------------------------------------------------------
	// agreement check reads stages two and three only, never stage one
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_held[i] = (s2[i] == s3[i]) ? s3[i] : held[i];
		end
	end

	// stage registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			held <= '0;
		end else begin
			s1 <= port.raw;
			s2 <= s1;
			s3 <= s2;
			held <= next_held;
		end
	end

	assign port.clean = held;
endmodule : plc_pin_sync

// [testbench/plc_panel_chk.sv]
// Purpose: port checker for the panel local control block
// Assumes: one clock, nrst active low
// Notes: key timing windows allow for the pin synchroniser
`timescale 1ns/10ps
module plc_panel_chk
	import plc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// inputs
	input wire logic keyStatus,
	input wire logic localSel,
	input wire logic [plc_pkg::REF_W-1:0] remoteRef,
	input wire logic parWrite,
	input wire logic parFromSerial,
	input wire logic [3:0] parId,
	input wire logic [plc_pkg::REF_W-1:0] parData,
	// outputs
	input wire logic [plc_pkg::DISP_W-1:0] disp1,
	input wire logic [2:0] panel_control_mode_sel,
	input wire logic panel_inch_key_enable,
	input wire logic revEnable,
	input wire logic resetEnable,
	input wire logic dataLock,
	input wire logic showLine1,
	input wire logic [plc_pkg::REF_W-1:0] speedRef,
	input wire logic forceOpen,
	input wire logic inputsAccepted,
	input wire logic jogCmd,
	input wire logic dirReverse,
	input wire logic tripReset,
	input wire logic parRejected
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// a slice cannot be handed to $past, so name it
	logic [5:0] dispData;
	assign dispData = parData[5:0];
	sequence statusRise;
		$rose(keyStatus) ##1 keyStatus[*2];
	endsequence
	sequence toRemote;
		$fell(localSel) && (panel_control_mode_sel inside {3'h3, 3'h4});
	endsequence
	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	a_lock_rejects: assert property (parWrite && !parFromSerial &&
		dataLock && parId > 4'h2 |=> parRejected)
		else $error("locked keypad edit was taken");
	a_disp_always: assert property (parWrite && parId == 4'h0
		|=> disp1 == $past(dispData)) else $error("display write lost");
	a_mode_off_local: assert property (parWrite && parId == 4'h3 &&
		parData[2:0] == 3'h0 && localSel
		|=> parRejected && $stable(panel_control_mode_sel))
		else $error("mode off accepted in local");
	a_open_forced: assert property (localSel &&
		(panel_control_mode_sel inside {3'h1, 3'h2}) |-> forceOpen)
		else $error("open loop not forced");
	a_keep_config: assert property (
		(panel_control_mode_sel inside {3'h3, 3'h4}) |-> !forceOpen)
		else $error("configuration forced in keep mode");
	a_inputs_modes: assert property (localSel &&
		(panel_control_mode_sel inside {3'h2, 3'h4}) |-> inputsAccepted)
		else $error("digital inputs not accepted");
	a_jog_gated: assert property (!panel_inch_key_enable &&
		$past(panel_inch_key_enable) == 1'b0 |-> !jogCmd)
		else $error("jog while disabled");
	a_trip_gated: assert property (tripReset |-> $past(resetEnable))
		else $error("trip reset while disabled");
	a_rev_gated: assert property (dirReverse != $past(dirReverse)
		|-> $past(revEnable) && $past(localSel) &&
		($past(panel_control_mode_sel) inside {3'h1, 3'h3}))
		else $error("direction changed without permission");
	a_status_shown: assert property (statusRise |-> ##[0:4] showLine1)
		else $error("status key not shown");
	a_remote_ref: assert property (toRemote
		|-> ##[1:3] speedRef == remoteRef) else $error("remote ref missing");
	a_settings_hold: assert property (!parWrite |=> $stable(disp1) &&
		$stable(panel_control_mode_sel) && $stable(dataLock))
		else $error("setting moved without write");
endmodule : plc_panel_chk
bind plc_panel_local plc_panel_chk plc_panel_chk_inst (
	.sys_clk(sys_clk), .nrst(nrst), .keyStatus(keyStatus),
	.localSel(localSel), .remoteRef(remoteRef), .parWrite(parWrite),
	.parFromSerial(parFromSerial), .parId(parId), .parData(parData),
	.disp1(disp1), .panel_control_mode_sel(panel_control_mode_sel),
	.panel_inch_key_enable(panel_inch_key_enable),
	.revEnable(revEnable), .resetEnable(resetEnable),
	.dataLock(dataLock), .showLine1(showLine1), .speedRef(speedRef),
	.forceOpen(forceOpen), .inputsAccepted(inputsAccepted),
	.jogCmd(jogCmd), .dirReverse(dirReverse), .tripReset(tripReset),
	.parRejected(parRejected));

// [testbench/plc_keypad_model.sv]
// Purpose: operator keypad and digital run input pins
// Assumes: released keys read low through a pull-down
// Notes: bit order stop, start, jog, dir, reset, status, run input
`timescale 1ns/10ps
module plc_keypad_model (
	// clock
	input wire logic sys_clk,
	// pins
	output logic [6:0] keys
);
	initial keys = 7'h00;
	// hold a key, then leave time for the synchroniser to settle
	task automatic press(input int k, input int n);
		@(posedge sys_clk);
		keys[k] <= 1'b1;
		repeat (n) @(posedge sys_clk);
		keys[k] <= 1'b0; // at least two cycles high and low per edge
		repeat (8) @(posedge sys_clk);
	endtask : press
endmodule : plc_keypad_model

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the panel local control block
// Assumes: settings written by one-cycle strobes, keys via model
// Notes: power-up codes other than the default need a mains model
`timescale 1ns/10ps
module tb_top;
	import plc_pkg::*;
	// -----------------------------------------------------------------
	// stimulus and observation
	// -----------------------------------------------------------------
	logic sys_clk = 1'b0, nrst = 1'b0, localSel = 1'b1;
	logic dirReversible = 1'b1;
	logic [6:0] keys;
	logic [REF_W-1:0] remoteRef = 16'h1234, presentRef = 16'h0456;
	logic [REF_W-1:0] parData = 16'h0000, speedRef;
	logic parWrite = 1'b0, parFromSerial = 1'b0, rej;
	logic [3:0] parId = 4'h0;
	logic [DISP_W-1:0] disp1, disp2, disp3;
	logic [2:0] modeSel;
	logic [1:0] pwrSel, configOut;
	logic stopEnable, jogEn, revEnable, resetEnable, dataLock;
	logic showLine1, forceOpen, inputsAccepted, runCmd, jogCmd;
	logic dirReverse, tripReset, parRejected;
	int num_errors = 0, tests_run = 0, cycles = 0;
	int tripCnt = 0, showCnt = 0, jogCnt = 0;
	always #50 sys_clk = ~sys_clk;
	plc_keypad_model plc_keypad_model_inst (.sys_clk(sys_clk), .keys(keys));
	plc_panel_local plc_panel_local_inst (.sys_clk(sys_clk), .nrst(nrst),
		.keyStop(keys[0]), .keyStart(keys[1]), .keyJog(keys[2]),
		.keyDir(keys[3]), .keyReset(keys[4]), .keyStatus(keys[5]),
		.dinRun(keys[6]), .localSel(localSel), .remoteRef(remoteRef),
		.presentRef(presentRef), .dirReversible(dirReversible),
		.storedConfig(2'h1), .dinFunction(4'h0), .savedRunState(1'b0),
		.parWrite(parWrite), .parFromSerial(parFromSerial), .parId(parId),
		.parData(parData), .disp1(disp1), .disp2(disp2), .disp3(disp3),
		.panel_control_mode_sel(modeSel), .stopEnable(stopEnable),
		.panel_inch_key_enable(jogEn), .revEnable(revEnable),
		.resetEnable(resetEnable), .dataLock(dataLock),
		.mains_on_behaviour_sel(pwrSel), .showLine1(showLine1),
		.speedRef(speedRef), .configOut(configOut), .forceOpen(forceOpen),
		.inputsAccepted(inputsAccepted), .runCmd(runCmd), .jogCmd(jogCmd),
		.dirReverse(dirReverse), .tripReset(tripReset),
		.parRejected(parRejected));
	// pulse counters and a ceiling well above the expected run
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (tripReset === 1'b1) tripCnt <= tripCnt + 1;
		if (showLine1 === 1'b1) showCnt <= showCnt + 1;
		if (jogCmd === 1'b1) jogCnt <= jogCnt + 1;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end
	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one-cycle write; refusal pulse is read just after the taking edge
	task automatic wr(input logic [3:0] id, input logic [15:0] d,
		input logic ser);
		@(posedge sys_clk);
		parWrite <= 1'b1;
		parId <= id;
		parData <= d;
		parFromSerial <= ser;
		@(posedge sys_clk);
		parWrite <= 1'b0;
		#1 rej = parRejected;
	endtask : wr
	task automatic summarize;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(disp1, 6'h01);
		chk(disp2, 6'h06);
		chk(disp3, 6'h08);
		chk(modeSel, MODE_DEF);
		chk({stopEnable, jogEn, revEnable, resetEnable}, 4'h9);
		chk({dataLock, pwrSel}, 3'h1);
		chk(runCmd, 1'b0);
		// lock blocks keypad edits but not display or serial ones
		wr(PAR_LOCK, 16'h0001, 1'b0);
		wr(PAR_STOP, 16'h0000, 1'b0);
		chk({rej, stopEnable}, 2'h3);
		wr(PAR_DISP2, 16'h0009, 1'b0);
		chk({rej, disp2}, 7'h09);
		wr(PAR_DISP1, 16'h000C, 1'b0);
		chk({rej, disp1}, 7'h0C);
		wr(PAR_JOG, 16'h0001, 1'b1);
		chk(jogEn, 1'b1);
		wr(PAR_LOCK, 16'h0000, 1'b1);
		wr(PAR_MODE, 16'h0000, 1'b0);
		chk({rej, modeSel}, 4'hC);
		for (int m = 1; m <= 4; m++) begin
			wr(PAR_MODE, 16'(m), 1'b0);
			chk(forceOpen, m == 1 || m == 2);
			chk(inputsAccepted, m == 2 || m == 4);
			// configuration output is registered one edge behind the mode
			@(posedge sys_clk);
			#1 chk(configOut, (m == 1 || m == 2) ? 2'h0 : 2'h1);
		end
		// mode off is only reachable from remote, then refuses local ref
		@(posedge sys_clk);
		localSel <= 1'b0;
		wr(PAR_MODE, 16'h0000, 1'b0);
		chk(rej, 1'b0);
		wr(PAR_LREF, 16'h0100, 1'b0);
		chk(rej, 1'b1);
		wr(PAR_MODE, 16'h0003, 1'b0);
		@(posedge sys_clk);
		localSel <= 1'b1;
		wr(PAR_JOG, 16'h0000, 1'b0);
		plc_keypad_model_inst.press(2, 4);
		chk(jogCnt, 0);
		wr(PAR_JOG, 16'h0001, 1'b0);
		plc_keypad_model_inst.press(2, 4);
		chk(jogCnt > 0, 1'b1);
		plc_keypad_model_inst.press(1, 4);
		chk(runCmd, 1'b1);
		wr(PAR_STOP, 16'h0000, 1'b0);
		plc_keypad_model_inst.press(0, 4);
		chk(runCmd, 1'b1);
		wr(PAR_STOP, 16'h0001, 1'b0);
		plc_keypad_model_inst.press(0, 4);
		chk(runCmd, 1'b0);
		wr(PAR_REV, 16'h0001, 1'b0);
		plc_keypad_model_inst.press(3, 4);
		chk(dirReverse, 1'b1);
		wr(PAR_MODE, 16'h0004, 1'b0);
		plc_keypad_model_inst.press(3, 4);
		chk(dirReverse, 1'b1);
		// panel reset only off when an external reset is wired
		wr(PAR_RST, 16'h0000, 1'b0);
		plc_keypad_model_inst.press(4, 4);
		chk(tripCnt, 0);
		wr(PAR_RST, 16'h0001, 1'b0);
		plc_keypad_model_inst.press(4, 4);
		chk(tripCnt, 1);
		plc_keypad_model_inst.press(5, 4);
		chk(showCnt, 1);
		@(posedge sys_clk);
		localSel <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk(speedRef, 16'h1234);
		// open-loop handover to local with a direction that cannot reverse
		dirReversible <= 1'b0;
		wr(PAR_MODE, 16'h0001, 1'b0);
		@(posedge sys_clk);
		localSel <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk(speedRef, 16'h0000);
		chk(configOut, 2'h0);
		// back to remote: present output first, stored configuration again
		@(posedge sys_clk);
		localSel <= 1'b0;
		@(posedge sys_clk);
		#1 chk(speedRef, 16'h0456);
		chk(configOut, 2'h1);
		summarize();
	end
endmodule : tb_top
